// ===== include/swudn_pkg.sv
// Shared constants and types for the single-wire UART datagram node.
package swudn_pkg;

	localparam int CLK_HZ      = 50_000_000;
	localparam int MIN_BAUD    = 9000;
	localparam int DEF_BIT_CYC = CLK_HZ / MIN_BAUD;

	localparam int GLITCH_CYC    = 16;
	localparam int SYNC_FALLS    = 2;
	localparam int SYNC_SHIFT    = 2;
	localparam int SYNC_NEXT_BIT = 3;
	localparam int DATA_BITS     = 8;

	localparam int TIMEOUT_BITS = 63;
	localparam int RECOVER_BITS = 12;
	localparam int RELEASE_BITS = 4;
	localparam int DELAY_STEP   = 8;

	localparam int IDX_ADDR = 1;
	localparam int IDX_REG  = 2;
	localparam int LEN_RD   = 4;
	localparam int LEN_WR   = 8;
	localparam int RW_BIT   = 7;

	localparam logic [2:0] SYNC_LOW_BITS = 3'h5;
	localparam logic [7:0] REPLY_SYNC    = 8'h05;
	localparam logic [7:0] REPLY_ADDR    = 8'hff;
	localparam logic [7:0] CRC_POLY      = 8'h07;
	localparam logic [7:0] CRC_INIT      = 8'h00;

	localparam int REG_W  = 7;
	localparam int WORD_W = 32;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_SYNC    = 4'h1,
		ST_DATA    = 4'h3,
		ST_STOP    = 4'h2,
		ST_GAP     = 4'h6,
		ST_START   = 4'h7,
		ST_DELAY   = 4'h5,
		ST_TX      = 4'h4,
		ST_RECOVER = 4'hc
	} swudn_state_e;

endpackage

// ===== verilog/swudn_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module swudn_fifo #(
	parameter int W     = 39,
	parameter int DEPTH = 16
) (
	input  wire logic         core_clk,  // System clock.
	input  wire logic         rst_b,     // Asynchronous reset, active low.
	input  wire logic         in_valid,  // Write word offered.
	output logic              in_ready,  // Room for a word.
	input  wire logic [W-1:0] in_data,   // Word to store.
	output logic              out_valid, // Word available.
	input  wire logic         out_ready, // Drain side takes the word.
	output logic [W-1:0]      out_data   // Oldest word.
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	logic         do_wr;
	logic         do_rd;

	assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign out_valid = wr_ptr != rd_ptr;
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
		end else if (do_wr) begin
			wr_ptr <= wr_ptr + (AW+1)'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ptr <= '0;
		end else if (do_rd) begin
			rd_ptr <= rd_ptr + (AW+1)'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (do_wr) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

endmodule

// ===== verilog/swudn_node.sv
// Single-wire UART datagram node: receiver, reply transmitter and write FIFO.
`timescale 1ns/10ps
module swudn_node #(
	parameter int              BT_W       = 16,
	parameter int              TMR_W      = 24,
	parameter int              FIFO_DEPTH = 16,
	parameter logic [BT_W-1:0] DEF_BIT    = BT_W'(swudn_pkg::DEF_BIT_CYC)
) (
	input  wire logic                          core_clk,               // System clock.
	input  wire logic                          rst_b,                  // Reset, active low.
	input  wire logic                          bus_line_true_in,       // Line level seen.
	output logic                               bus_line_true_out,      // Line level driven.
	output logic                               bus_line_true_oe_b,     // Low while driving.
	input  wire logic                          bus_line_inverted_in,   // Inverted line seen.
	output logic                               bus_line_inverted_out,  // Inverted level.
	output logic                               bus_line_inverted_oe_b, // Low while driving.
	input  wire logic [7:0]                    node_address_setting,   // Base node address.
	input  wire logic                          address_increment_pin,  // Adds one to address.
	input  wire logic [3:0]                    reply_delay_setting,    // Delay in 8-bit steps.
	output logic                               wr_valid,               // Write word ready.
	input  wire logic                          wr_ready,               // Write word taken.
	output logic [swudn_pkg::REG_W-1:0]        wr_reg,                 // Written register.
	output logic [swudn_pkg::WORD_W-1:0]       wr_data,                // Written data.
	output logic                               rd_req,                 // Read request pulse.
	output logic [swudn_pkg::REG_W-1:0]        rd_reg,                 // Register to read.
	input  wire logic [swudn_pkg::WORD_W-1:0]  rd_data,                // Read data word.
	output logic [7:0]                         datagram_count,         // Accepted writes.
	output logic [BT_W-1:0]                    bit_time                // Current bit time.
);
	import swudn_pkg::*;

	localparam int PH_W = BT_W + 2;
	localparam int FW   = REG_W + WORD_W;

	// A low pulse of n cycles shows its rising edge at phase n-1.
	localparam logic [PH_W-1:0] GLITCH    = PH_W'(GLITCH_CYC - 1);
	localparam logic [1:0]      FALL_LAST = 2'(SYNC_FALLS - 1);
	localparam logic [3:0]      BIT_SYNC  = 4'(SYNC_NEXT_BIT);
	localparam logic [3:0]      BIT_LAST  = 4'(DATA_BITS - 1);
	localparam logic [3:0]      TX_DLAST  = 4'(DATA_BITS);
	localparam logic [3:0]      TX_STOP   = 4'(DATA_BITS + 1);
	localparam logic [3:0]      TX_LAST   = 4'(DATA_BITS + 1 + RELEASE_BITS);
	localparam logic [2:0]      B_ADDR    = 3'(IDX_ADDR);
	localparam logic [2:0]      B_REG     = 3'(IDX_REG);
	localparam logic [2:0]      B_WRLAST  = 3'(LEN_WR - 1);
	localparam logic [2:0]      B_RDLAST  = 3'(LEN_RD - 1);

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int j = 0; j < 8; j++) begin
			if (r[7] ^ d[j]) begin
				r = {r[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[6:0], 1'b0};
			end
		end
		return r;
	endfunction

	swudn_state_e    state;
	swudn_state_e    next_state;
	logic [1:0]      rx_sync;
	logic [1:0]      inc_sync;
	logic            rx;
	logic            rx_d;
	logic            fall;
	logic [PH_W-1:0] phase;
	logic [PH_W-1:0] half;
	logic [PH_W-1:0] bt_last;
	logic [1:0]      falls;
	logic [3:0]      bit_idx;
	logic [2:0]      byte_idx;
	logic [TMR_W-1:0] tmr;
	logic [TMR_W-1:0] lim_gap;
	logic [TMR_W-1:0] lim_rec;
	logic [TMR_W-1:0] lim_dly;
	logic [3:0]      dly_steps;
	logic [BT_W-1:0] good_bt;
	logic [7:0]      sh;
	logic [7:0]      crc;
	logic [7:0]      dg [LEN_WR];
	logic [7:0]      my_addr;
	logic            addr_ok;
	logic            is_wr;
	logic            last_byte;
	logic            crc_ok;
	logic            byte_end;
	logic            accept;
	logic            frame_ok;
	logic            push;
	logic            fifo_ready;
	logic            glitch;
	logic [WORD_W-1:0] reply;
	logic [7:0]      tx_cur;
	logic            drive_b;
	logic            level;
	logic [FW-1:0]   fifo_out;

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers. The inverted line is not needed for listening.

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_sync <= 2'h3;
			rx_d    <= 1'b1;
		end else begin
			rx_sync <= {rx_sync[0], bus_line_true_in};
			rx_d    <= rx_sync[1];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			inc_sync <= 2'h0;
		end else begin
			inc_sync <= {inc_sync[0], address_increment_pin};
		end
	end

	assign rx   = rx_sync[1];
	assign fall = rx_d && !rx;

	////////////////////////////////////////////////////////////////////////////
	// Decode of the datagram being received.

	assign my_addr   = node_address_setting + {7'h00, inc_sync[1]};
	assign addr_ok   = (dg[B_ADDR] == my_addr) && (my_addr != REPLY_ADDR);
	assign is_wr     = dg[B_REG][RW_BIT];
	assign last_byte = (byte_idx > B_REG) && (byte_idx == (is_wr ? B_WRLAST : B_RDLAST));
	assign crc_ok    = sh == crc;
	assign byte_end  = (state == ST_STOP) && (phase == half) && rx;
	assign accept    = addr_ok && (!is_wr || fifo_ready);
	assign frame_ok  = byte_end && last_byte && crc_ok && accept;
	assign push      = frame_ok && is_wr;

	assign half      = PH_W'(bit_time >> 1);
	assign bt_last   = PH_W'(bit_time) - PH_W'(1);
	assign glitch    = rx && (phase < GLITCH);
	assign dly_steps = (reply_delay_setting == 4'h0) ? 4'h1 : reply_delay_setting;
	assign lim_gap   = TMR_W'(good_bt * TIMEOUT_BITS);
	assign lim_rec   = TMR_W'(good_bt * RECOVER_BITS);
	assign lim_dly   = TMR_W'(bit_time * DELAY_STEP * dly_steps);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (fall) begin
					next_state = ST_SYNC;
				end
			end
			ST_SYNC: begin
				if (glitch || &phase) begin
					next_state = ST_RECOVER;
				end else if (fall && falls == FALL_LAST) begin
					next_state = ST_DATA;
				end
			end
			ST_START: begin
				if (glitch || (rx && phase == half)) begin
					next_state = ST_RECOVER;
				end else if (phase == bt_last) begin
					next_state = ST_DATA;
				end
			end
			ST_DATA: begin
				if (phase == bt_last && bit_idx == BIT_LAST) begin
					next_state = ST_STOP;
				end
			end
			ST_STOP: begin
				if (phase == half) begin
					if (!rx) begin
						next_state = ST_RECOVER;
					end else if (!last_byte) begin
						next_state = ST_GAP;
					end else if (!crc_ok) begin
						next_state = ST_RECOVER;
					end else if (accept && !is_wr) begin
						next_state = ST_DELAY;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_GAP: begin
				if (fall) begin
					next_state = ST_START;
				end else if (tmr > lim_gap) begin
					next_state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (rx && tmr >= lim_rec) begin
					next_state = ST_IDLE;
				end
			end
			ST_DELAY: begin
				if (tmr >= lim_dly - TMR_W'(1)) begin
					next_state = ST_TX;
				end
			end
			ST_TX: begin
				if (phase == bt_last && bit_idx == TX_LAST && byte_idx == B_WRLAST) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bit phase, bit index and byte index.

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= '0;
		end else if (next_state != state ||
			((state == ST_DATA || state == ST_TX) && phase == bt_last)) begin
			phase <= '0;
		end else if (state inside {ST_SYNC, ST_START, ST_DATA, ST_STOP, ST_TX}) begin
			phase <= phase + PH_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			falls <= 2'h0;
		end else if (state != ST_SYNC) begin
			falls <= 2'h0;
		end else if (fall) begin
			falls <= falls + 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_idx <= 4'h0;
		end else if (next_state != state) begin
			bit_idx <= (state == ST_SYNC) ? BIT_SYNC : 4'h0;
		end else if ((state == ST_DATA || state == ST_TX) && phase == bt_last) begin
			if (state == ST_TX && bit_idx == TX_STOP && byte_idx != B_WRLAST) begin
				bit_idx <= 4'h0;
			end else begin
				bit_idx <= bit_idx + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_idx <= 3'h0;
		end else if (next_state != state && next_state inside {ST_SYNC, ST_TX}) begin
			byte_idx <= 3'h0;
		end else if (byte_end && !last_byte) begin
			byte_idx <= byte_idx + 3'h1;
		end else if (state == ST_TX && phase == bt_last && bit_idx == TX_STOP &&
			byte_idx != B_WRLAST) begin
			byte_idx <= byte_idx + 3'h1;
		end
	end

	// One timer serves the byte gap, the recovery idle time and the reply delay.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tmr <= '0;
		end else if (fall && (state == ST_IDLE || state == ST_GAP)) begin
			tmr <= '0;
		end else if (next_state != state && next_state inside {ST_RECOVER, ST_DELAY}) begin
			tmr <= '0;
		end else if (state == ST_RECOVER && !rx) begin
			tmr <= '0;
		end else if (!(&tmr)) begin
			tmr <= tmr + TMR_W'(1);
		end
	end

	// Four bit times span start falling edge to the bit 2 to bit 3 edge.
	// That edge is seen at phase span-1, so one is added before the divide.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_time <= DEF_BIT;
		end else if (state == ST_SYNC && next_state == ST_DATA) begin
			bit_time <= BT_W'((phase + PH_W'(1)) >> SYNC_SHIFT);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			good_bt <= DEF_BIT;
		end else if (byte_end && last_byte && crc_ok) begin
			good_bt <= bit_time;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte assembly, datagram store and CRC.

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sh <= 8'h00;
		end else if (state == ST_SYNC && next_state == ST_DATA) begin
			sh[2:0] <= SYNC_LOW_BITS;
		end else if (state == ST_DATA && phase == half) begin
			sh[bit_idx[2:0]] <= rx;
		end
	end

	always_ff @(posedge core_clk) begin
		if (byte_end && !last_byte) begin
			dg[byte_idx] <= sh;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			crc <= CRC_INIT;
		end else if (state == ST_IDLE || state == ST_DELAY) begin
			crc <= CRC_INIT;
		end else if (byte_end) begin
			crc <= crc8(crc, sh);
		end else if (state == ST_TX && phase == bt_last && bit_idx == TX_DLAST) begin
			crc <= crc8(crc, tx_cur);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read request, reply word and write counter.

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_req <= 1'b0;
			rd_reg <= '0;
		end else begin
			rd_req <= frame_ok && !is_wr;
			if (frame_ok && !is_wr) begin
				rd_reg <= dg[B_REG][REG_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reply <= '0;
		end else if (state == ST_DELAY && next_state == ST_TX) begin
			reply <= rd_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			datagram_count <= 8'h00;
		end else if (push) begin
			datagram_count <= datagram_count + 8'h01;
		end
	end

	always_comb begin
		unique case (byte_idx)
			3'h0: tx_cur = REPLY_SYNC;
			3'h1: tx_cur = REPLY_ADDR;
			3'h2: tx_cur = {1'b0, rd_reg};
			3'h3: tx_cur = reply[31:24];
			3'h4: tx_cur = reply[23:16];
			3'h5: tx_cur = reply[15:8];
			3'h6: tx_cur = reply[7:0];
			3'h7: tx_cur = crc;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Line drivers. The bit clock is the request's own bit time.

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_b <= 1'b1;
			level   <= 1'b1;
		end else begin
			drive_b <= state != ST_TX;
			if (state != ST_TX || bit_idx > TX_DLAST) begin
				level <= 1'b1;
			end else if (bit_idx == 4'h0) begin
				level <= 1'b0;
			end else begin
				level <= tx_cur[3'(bit_idx - 4'h1)];
			end
		end
	end

	assign bus_line_true_out      = level;
	assign bus_line_inverted_out  = !level;
	assign bus_line_true_oe_b     = drive_b;
	assign bus_line_inverted_oe_b = drive_b;

	////////////////////////////////////////////////////////////////////////////
	// Write FIFO; a full FIFO refuses the write and leaves the counter alone.

	swudn_fifo #(
		.W     (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   ({dg[B_REG][REG_W-1:0], dg[3], dg[4], dg[5], dg[6]}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (fifo_out)
	);

	assign wr_reg  = fifo_out[FW-1:WORD_W];
	assign wr_data = fifo_out[WORD_W-1:0];

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_GLITCH: assert property ((state == ST_SYNC || state == ST_START) && glitch |=>
		state == ST_RECOVER)
		else $error("short pulse did not force recovery");
	AST_CRC_BAD: assert property (byte_end && last_byte && !crc_ok |=> state == ST_RECOVER)
		else $error("bad crc did not force recovery");
	AST_TIMEOUT: assert property (state == ST_GAP && !fall && tmr > lim_gap |=> state == ST_RECOVER)
		else $error("byte gap timeout missed");
	AST_CNT_STEP: assert property (datagram_count != $past(datagram_count) |->
		datagram_count == $past(datagram_count) + 8'h01 && $past(push))
		else $error("counter moved without accepted write");
	AST_RD_NO_CNT: assert property (rd_req |-> $stable(datagram_count))
		else $error("read changed counter");
	AST_OWN_ADDR: assert property (rd_req |-> $past(my_addr) != REPLY_ADDR &&
		$past(dg[B_ADDR]) == $past(my_addr))
		else $error("accepted reserved or foreign address");
	AST_OE_TX: assert property (!bus_line_true_oe_b |-> $past(state) == ST_TX)
		else $error("driver enabled outside reply");
	AST_START_BIT: assert property (state == ST_TX && bit_idx == 4'h0 |=> !bus_line_true_out)
		else $error("start bit not low");
	AST_RELEASE: assert property ($rose(bus_line_true_oe_b) |->
		$past(bit_idx, 2) == TX_LAST && bus_line_true_out)
		else $error("drivers released at wrong time");
	AST_DELAY: assert property (rd_req |-> bus_line_true_oe_b [*8])
		else $error("reply started without delay");

endmodule

// ===== dv/swudn_host.sv
// Host UART model that drives and listens on the shared single wire.
`timescale 1ns/10ps
module swudn_host #(
	parameter int BT = 20 // Cycles per bit, fixed for the whole run.
) (
	input  wire logic core_clk, // System clock.
	input  wire logic line,     // Resolved line level.
	output logic      drv_b,    // Low while the host drives.
	output logic      drv       // Level driven.
);
	initial begin
		drv_b = 1'b1;
		drv = 1'b1;
	end

	function automatic logic [7:0] crc_of(input logic [63:0] m, input int n);
		logic [7:0] c;
		logic [7:0] b;
		c = 8'h00;
		for (int i = 0; i < n; i++) begin
			b = m[63-8*i -: 8];
			for (int j = 0; j < 8; j++)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ b[j]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction

	task automatic bit_out(input logic v);
		drv_b <= 1'b0;
		drv <= v;
		repeat (BT) @(posedge core_clk);
	endtask

	// Sends n bytes of m, the last replaced by the CRC; idle and gap are in bit times.
	task automatic send(input logic [63:0] m, input int n, input logic bad, input int gap,
		input int idle);
		logic [7:0] b;
		// The idle time leaves the line released to its pull-up.
		repeat (idle * BT) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			b = (i == n-1) ? crc_of(m, n-1) ^ {7'h00, bad} : m[63-8*i -: 8];
			bit_out(1'b0);
			for (int j = 0; j < 8; j++)
				bit_out(b[j]);
			bit_out(1'b1);
			if (i == 1)
				repeat (gap) bit_out(1'b1);
		end
		drv_b <= 1'b1;
	endtask

	task automatic glitch();
		@(posedge core_clk);
		drv_b <= 1'b0;
		drv <= 1'b0;
		repeat (8) @(posedge core_clk);
		drv_b <= 1'b1;
	endtask

	// Receives eight bytes sampled mid-bit; ok drops on a framing fault or a timeout.
	task automatic get(output logic [63:0] r, output logic ok);
		logic [7:0] b;
		int k;
		ok = 1'b1;
		r = 64'h0;
		for (int i = 0; i < 8; i++) begin
			k = 0;
			while (line !== 1'b0 && k < 4000) begin
				@(posedge core_clk);
				k++;
			end
			repeat (BT/2) @(posedge core_clk);
			if (line !== 1'b0)
				ok = 1'b0;
			for (int j = 0; j < 8; j++) begin
				repeat (BT) @(posedge core_clk);
				b[j] = line;
			end
			repeat (BT) @(posedge core_clk);
			if (line !== 1'b1)
				ok = 1'b0;
			r = {r[55:0], b};
		end
	endtask
endmodule

// ===== dv/swudn_node_tb.sv
// Self-checking testbench for the datagram node.
`timescale 1ns/10ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin \
	failures++; $display("BAD t=%0t %s", $time, m); end end
module swudn_node_tb;
	import swudn_pkg::*;
	localparam int BT = 20;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr_set = 8'h12;
	logic        inc = 1'b0;
	logic [3:0]  dly_set = 4'h1;
	logic        wr_ready = 1'b0;
	logic [31:0] rd_data = 32'h0;
	logic        t_out, t_oe_b, i_out, i_oe_b, h_drv_b, h_drv, wr_valid, rd_req;
	logic [6:0]  wr_reg, rd_reg;
	logic [31:0] wr_data;
	logic [7:0]  datagram_count;
	logic [15:0] bit_time;
	int          failures = 0;
	int          samples_checked = 0;
	int          drv_cyc = 0;
	int          rd_cnt = 0;
	wire         line = !t_oe_b ? t_out : (!h_drv_b ? h_drv : 1'b1);
	wire         line_n = ~line;

	always #10 core_clk = ~core_clk;

	swudn_node #(.DEF_BIT(16'd100)) dut (.core_clk(core_clk), .rst_b(rst_b),
		.bus_line_true_in(line), .bus_line_true_out(t_out), .bus_line_true_oe_b(t_oe_b),
		.bus_line_inverted_in(line_n), .bus_line_inverted_out(i_out),
		.bus_line_inverted_oe_b(i_oe_b), .node_address_setting(addr_set),
		.address_increment_pin(inc), .reply_delay_setting(dly_set), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_reg(wr_reg), .wr_data(wr_data), .rd_req(rd_req),
		.rd_reg(rd_reg), .rd_data(rd_data), .datagram_count(datagram_count),
		.bit_time(bit_time));

	swudn_host #(.BT(BT)) host (.core_clk(core_clk), .line(line), .drv_b(h_drv_b), .drv(h_drv));

	always @(posedge core_clk) begin
		if (!t_oe_b)
			drv_cyc <= drv_cyc + 1;
		if (rd_req === 1'b1)
			rd_cnt <= rd_cnt + 1;
	end

	always @(negedge core_clk) if (rst_b) begin
		`CHK(i_oe_b, t_oe_b, "enable pair")
		`CHK(t_oe_b | h_drv_b, 1'b1, "contention")
		if (!t_oe_b) `CHK(i_out, ~t_out, "inverted level")
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wait_oe(input logic v, output int k);
		k = 0;
		while (t_oe_b !== v) begin
			@(posedge core_clk);
			k++;
			if (k > 4000) begin
				failures++;
				$display("BAD t=%0t timeout", $time);
				give_verdict();
			end
		end
	endtask

	task automatic pop();
		@(posedge core_clk) wr_ready <= 1'b1;
		@(posedge core_clk) wr_ready <= 1'b0;
		@(negedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic bad,
		input int gap, input int idle, input logic take);
		logic [7:0] c0;
		c0 = datagram_count;
		host.send({8'ha5, a, 8'h85, d, 8'h00}, 8, bad, gap, idle);
		repeat (8) @(negedge core_clk);
		`CHK(datagram_count, c0 + 8'(take), "write count")
		`CHK(wr_valid, take, "write pushed")
		if (take) begin
			`CHK(wr_reg, 7'h05, "write register")
			`CHK(wr_data, d, "write data")
			pop();
			`CHK(wr_valid, 1'b0, "fifo empty")
		end
	endtask

	task automatic t_basic();
		`CHK(datagram_count, 8'h00, "reset count")
		`CHK(bit_time, 16'd100, "reset bit time")
		`CHK(t_oe_b, 1'b1, "reset drivers off")
		wr(8'h12, 32'hdeadbeef, 1'b0, 0, 12, 1'b1);
		`CHK(bit_time, 16'(BT), "bit time")
	endtask

	task automatic t_addr();
		@(posedge core_clk) inc <= 1'b1;
		wr(8'h12, 32'h1, 1'b0, 0, 12, 1'b0);
		wr(8'h13, 32'h2, 1'b0, 0, 12, 1'b1);
		@(posedge core_clk) addr_set <= 8'hfe;
		wr(8'hff, 32'h3, 1'b0, 0, 12, 1'b0);
		@(posedge core_clk) addr_set <= 8'h12;
		inc <= 1'b0;
	endtask

	task automatic t_err();
		wr(8'h12, 32'h4, 1'b1, 0, 12, 1'b0);
		wr(8'h12, 32'h5, 1'b0, 0, 12, 1'b1);
		host.glitch();
		wr(8'h12, 32'h6, 1'b0, 0, 2, 1'b0);
		wr(8'h12, 32'h7, 1'b0, 0, 12, 1'b1);
		wr(8'h12, 32'h8, 1'b0, 60, 12, 1'b0);
		wr(8'h12, 32'h9, 1'b0, 0, 12, 1'b1);
	endtask

	task automatic t_read(input logic [3:0] set, input int steps, input logic [6:0] rg,
		input logic [31:0] d);
		logic [63:0] e, r;
		logic ok;
		logic [7:0] c0;
		int k, k2, r0, d0;
		c0 = datagram_count;
		r0 = rd_cnt;
		d0 = drv_cyc;
		@(posedge core_clk) dly_set <= set;
		rd_data <= d;
		host.send({8'ha5, 8'h12, 1'b0, rg, 40'h0}, 4, 1'b0, 0, 12);
		fork
			host.get(r, ok);
			wait_oe(1'b0, k);
		join
		wait_oe(1'b1, k2);
		@(negedge core_clk);
		e = {8'h05, 8'hff, 1'b0, rg, d, 8'h00};
		e[7:0] = host.crc_of(e, 7);
		`CHK(ok, 1'b1, "reply framing")
		`CHK(r, e, "reply content")
		`CHK(k >= steps*8*BT - BT && k <= steps*8*BT + 4, 1'b1, "reply delay")
		`CHK(drv_cyc - d0 >= 84*BT - 2 && drv_cyc - d0 <= 84*BT + 2, 1'b1, "release")
		`CHK(rd_cnt - r0, 1, "read pulse")
		`CHK(rd_reg, rg, "read register")
		`CHK(datagram_count, c0, "read count")
	endtask

	task automatic t_fill();
		logic [7:0] c0;
		c0 = datagram_count;
		for (int i = 0; i < 17; i++)
			host.send({8'ha5, 8'h12, 1'b1, 7'(i), 32'(i*3), 8'h00}, 8, 1'b0, 0, 12);
		repeat (8) @(negedge core_clk);
		`CHK(datagram_count, c0 + 8'd16, "full fifo drop")
		for (int i = 0; i < 16; i++) begin
			`CHK(wr_valid, 1'b1, "fifo level")
			`CHK(wr_reg, 7'(i), "fifo order")
			`CHK(wr_data, 32'(i*3), "fifo data")
			pop();
		end
		`CHK(wr_valid, 1'b0, "fifo drained")
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(negedge core_clk);
		t_basic();
		t_addr();
		t_err();
		t_read(4'h2, 2, 7'h23, 32'h12345678);
		t_read(4'h0, 1, 7'h7f, 32'h80c00001);
		t_fill();
		give_verdict();
	end
endmodule
